// >>> emim_top.sv
// external memory interface mode logic: config, routing, bus phases
// assumes cpu issues one external-move request and waits for done
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module emim_top
  import emim_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // cpu external-move port
  input  wire logic        xreq_in,
  input  wire logic        xwrite_in,
  input  wire logic        xwide_in,
  input  wire logic [15:0] xaddr_in,
  input  wire logic [7:0]  xwdata_in,
  input  wire logic [7:0]  port_hi_latch_in,
  output logic             xdone_out,
  output logic      [7:0]  xrdata_out,
  // external pins
  output logic      [7:0]  ad_out,
  output logic      [7:0]  ad_oe_out,
  input  wire logic [7:0]  ad_in,
  output logic      [7:0]  addr_lo_out,
  output logic      [7:0]  addr_hi_out,
  output logic             addr_hi_oe_out,
  output logic             ale_out,
  output logic             rd_n_out,
  output logic             wr_n_out
);
  import emim_pkg::*;

  // ----------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------
  logic [7:0]  cfg_reg;
  logic [7:0]  page_reg;
  logic [13:0] idx;
  logic        wr_en;
  logic        rd_setup;
  logic        hit;
  emim_state_e state_reg;
  emim_state_e state_next;

  // word index match; byte lanes below the index are ignored
  function automatic logic reg_sel(input logic [13:0] i, input logic [11:0] r);
    reg_sel = (i == {2'b00, r});
  endfunction

  assign idx      = paddr[15:2];
  assign wr_en    = psel && penable && pwrite;
  // read data launched in setup so it stands for the whole access phase
  assign rd_setup = psel && !penable && !pwrite;
  assign hit      = reg_sel(idx, EMIM_CFG_IDX) || reg_sel(idx, EMIM_PAGE_IDX)
                 || reg_sel(idx, EMIM_STAT_IDX);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;

  // configuration; unused top bits never stored
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_reg <= EMIM_CFG_RESET;
    end else if (wr_en && reg_sel(idx, EMIM_CFG_IDX)) begin
      cfg_reg <= pwdata[7:0] & EMIM_CFG_WMASK;
    end
  end

  // page select for 8-bit accesses
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      page_reg <= EMIM_PAGE_RESET;
    end else if (wr_en && reg_sel(idx, EMIM_PAGE_IDX)) begin
      page_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      if (reg_sel(idx, EMIM_CFG_IDX)) begin
        prdata <= {24'h000000, cfg_reg & EMIM_CFG_WMASK};
      end else if (reg_sel(idx, EMIM_PAGE_IDX)) begin
        prdata <= {24'h000000, page_reg};
      end else if (reg_sel(idx, EMIM_STAT_IDX)) begin
        prdata <= {26'h0000000, state_reg};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  // upper byte of effective address; 8-bit accesses use the page
  function automatic logic [15:0] eff_addr(input logic wide, input logic [15:0] a,
                                           input logic [7:0] pg);
    eff_addr = wide ? a : {pg, a[7:0]};
  endfunction

  logic [15:0] ea;
  logic        offchip;
  emim_mode_e  mode;

  assign mode = emim_mode_e'(cfg_reg[EMIM_MODE_LSB +: 2]);
  assign ea   = eff_addr(xwide_in, xaddr_in, page_reg);

  always_comb begin
    case (mode)
      EMIM_MODE_INT:   offchip = 1'b0;
      EMIM_MODE_SPLIT: offchip = (ea[15:8] >= EMIM_ONCHIP_PAGES);
      EMIM_MODE_BANK:  offchip = (ea[15:8] >= EMIM_ONCHIP_PAGES);
      EMIM_MODE_EXT:   offchip = 1'b1;
      default:         offchip = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // captured access; config frozen for its whole length
  // ----------------------------------------------------------------
  logic [15:0] a_reg;
  logic [15:0] a_next;
  logic [7:0]  wd_reg;
  logic [7:0]  wd_next;
  logic        we_reg;
  logic        we_next;
  logic        mux_reg;
  logic        mux_next;
  logic        hi_drive_reg;
  logic        hi_drive_next;
  logic [1:0]  ale_w_reg;
  logic [1:0]  cnt_reg;
  logic        start;

  // refused in the done cycle, so a request still held is not served twice
  assign start = (state_reg == EMIM_IDLE) && xreq_in && !xdone_out;

  // pins launched at the take edge must already see the new access
  assign a_next        = start ? ea : a_reg;
  assign wd_next       = start ? xwdata_in : wd_reg;
  assign we_next       = start ? xwrite_in : we_reg;
  assign mux_next      = start ? !cfg_reg[EMIM_MUX_BIT] : mux_reg;
  // 8-bit off-chip without bank select: port latches own the upper byte
  assign hi_drive_next = start ? (xwide_in || (mode == EMIM_MODE_BANK))
                               : hi_drive_reg;

  // snapshot so a later register write leaves this access alone
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      a_reg        <= 16'h0000;
      wd_reg       <= 8'h00;
      we_reg       <= 1'b0;
      mux_reg      <= 1'b0;
      hi_drive_reg <= 1'b0;
    end else begin
      a_reg        <= a_next;
      wd_reg       <= wd_next;
      we_reg       <= we_next;
      mux_reg      <= mux_next;
      hi_drive_reg <= hi_drive_next;
    end
  end

  // latch pulse width, taken once per access
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ale_w_reg <= 2'h0;
    end else if (start) begin
      ale_w_reg <= cfg_reg[EMIM_ALE_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EMIM_IDLE: if (start) begin
        if (!offchip) begin
          state_next = EMIM_ONCH;
        end else if (!cfg_reg[EMIM_MUX_BIT]) begin
          state_next = EMIM_ALEH;
        end else begin
          state_next = EMIM_STRB;
        end
      end
      EMIM_ONCH: state_next = EMIM_TAIL;
      EMIM_ALEH: if (cnt_reg == ale_w_reg) begin
        state_next = EMIM_ALEL;
      end
      EMIM_ALEL: if (cnt_reg == ale_w_reg) begin
        state_next = EMIM_STRB;
      end
      EMIM_STRB: if (cnt_reg == 2'(EMIM_STROBE_CYC - 1)) begin
        state_next = EMIM_TAIL;
      end
      EMIM_TAIL: if (cnt_reg == 2'(EMIM_TAIL_CYC - 1)) begin
        state_next = EMIM_IDLE;
      end
      default: state_next = EMIM_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= EMIM_IDLE;
      cnt_reg   <= 2'h0;
    end else begin
      state_reg <= state_next;
      // field value plus one cycles per latch phase
      cnt_reg   <= (state_next != state_reg) ? 2'h0 : cnt_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // on-chip memory
  // ----------------------------------------------------------------
  logic [7:0] ram_q;

  emim_ram u_ram (
    .clk_sys_in (clk_sys_in),
    .en_in      (state_reg == EMIM_ONCH),
    .we_in      (we_reg),
    .addr_in    (a_reg[EMIM_ONCHIP_AW-1:0]),
    .wdata_in   (wd_reg),
    .rdata_out  (ram_q)
  );

  // ----------------------------------------------------------------
  // pins and cpu answer
  // ----------------------------------------------------------------
  // states that own the external pins
  function automatic logic ext_state(input emim_state_e s);
    ext_state = (s == EMIM_ALEH) || (s == EMIM_ALEL) || (s == EMIM_STRB);
  endfunction

  logic ext_act;
  logic was_off_reg;

  assign ext_act = ext_state(state_reg);

  // latch strobe, high for the whole first phase
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ale_out <= 1'b0;
    end else begin
      ale_out <= (state_next == EMIM_ALEH);
    end
  end

  // load and store strobes, one cycle each, never together
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
    end else begin
      rd_n_out <= !((state_next == EMIM_STRB) && !we_next);
      wr_n_out <= !((state_next == EMIM_STRB) && we_next);
    end
  end

  // shared lines: low address through both latch phases, then data
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ad_out    <= 8'h00;
      ad_oe_out <= 8'h00;
    end else if (state_next == EMIM_ALEH || state_next == EMIM_ALEL) begin
      // held past the strobe fall so the latch never sees a moving input
      ad_out    <= a_next[7:0];
      ad_oe_out <= 8'hFF;
    end else if (state_next == EMIM_STRB) begin
      ad_out    <= wd_next;
      ad_oe_out <= {8{we_next}};
    end else begin
      ad_out    <= 8'h00;
      ad_oe_out <= 8'h00;
    end
  end

  // separate low address pins only when not multiplexed
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_lo_out <= 8'h00;
    end else if (!mux_next && state_next == EMIM_STRB) begin
      addr_lo_out <= a_next[7:0];
    end else begin
      addr_lo_out <= 8'h00;
    end
  end

  // upper byte: own address, or the port latches when left undriven
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_hi_out    <= 8'h00;
      addr_hi_oe_out <= 1'b0;
    end else begin
      addr_hi_out    <= hi_drive_next ? a_next[15:8] : port_hi_latch_in;
      addr_hi_oe_out <= ext_state(state_next) && hi_drive_next;
    end
  end

  // where the last access went, so on-chip data never overwrites a load
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      was_off_reg <= 1'b0;
    end else if (state_reg == EMIM_ONCH) begin
      was_off_reg <= 1'b0;
    end else if (ext_act) begin
      was_off_reg <= 1'b1;
    end
  end

  // external data sampled at the end of the read strobe
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      xrdata_out <= 8'h00;
    end else if (state_reg == EMIM_STRB && !we_reg) begin
      xrdata_out <= ad_in;
    end else if (state_reg == EMIM_TAIL && cnt_reg == 2'h0 && !was_off_reg && !we_reg) begin
      xrdata_out <= ram_q;
    end
  end

  // done pulse, one cycle after the tail
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      xdone_out <= 1'b0;
    end else begin
      xdone_out <= (state_reg == EMIM_TAIL) && (state_next == EMIM_IDLE);
    end
  end
endmodule
`default_nettype wire

// >>> emim_pkg.sv
// package for the external memory interface mode block
// assumes apb 32-bit data, one aligned word per register
package emim_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] EMIM_CFG_IDX       = 12'h0AB;
  localparam logic [11:0] EMIM_PAGE_IDX      = 12'h0AA;
  localparam logic [11:0] EMIM_STAT_IDX      = 12'h0AC;
  localparam logic [7:0]  EMIM_CFG_RESET     = 8'h03;
  localparam logic [7:0]  EMIM_PAGE_RESET    = 8'h00;
  localparam logic [7:0]  EMIM_CFG_WMASK     = 8'h1F;
  localparam int          EMIM_MUX_BIT       = 4;
  localparam int          EMIM_MODE_LSB      = 2;
  localparam int          EMIM_ALE_LSB       = 0;
  // ----------------------------------------------------------------
  // memory and timing
  // ----------------------------------------------------------------
  localparam int          EMIM_ONCHIP_AW     = 13;
  localparam logic [7:0]  EMIM_ONCHIP_PAGES  = 8'h20;
  localparam int          EMIM_STROBE_CYC    = 1;
  localparam int          EMIM_TAIL_CYC      = 2;

  typedef enum logic [1:0] {
    EMIM_MODE_INT   = 2'b00,
    EMIM_MODE_SPLIT = 2'b01,
    EMIM_MODE_BANK  = 2'b10,
    EMIM_MODE_EXT   = 2'b11
  } emim_mode_e;

  typedef enum logic [5:0] {
    EMIM_IDLE  = 6'b000001,
    EMIM_ONCH  = 6'b000010,
    EMIM_ALEH  = 6'b000100,
    EMIM_ALEL  = 6'b001000,
    EMIM_STRB  = 6'b010000,
    EMIM_TAIL  = 6'b100000
  } emim_state_e;
endpackage

// >>> emim_ram.sv
// on-chip extended data memory, 8 kB, registered read data
// assumes single clock, one access per cycle
`timescale 1ns/1ps
`default_nettype none
module emim_ram (
  input  wire logic        clk_sys_in,
  input  wire logic        en_in,
  input  wire logic        we_in,
  input  wire logic [12:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem [0:8191];

  always_ff @(posedge clk_sys_in) begin
    if (en_in && we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (en_in) begin
      rdata_out <= mem[addr_in];
    end
  end
endmodule
`default_nettype wire

// >>> emim_sram.sv
// partner model: byte-wide static memory behind a transparent address latch
// assumes the bench says how the board is wired (mux_in) and resolves the bus
`timescale 1ns/1ps
`default_nettype none
module emim_sram (
  input  wire logic       mux_in,
  input  wire logic [7:0] port_hi_in,
  input  wire logic [7:0] ad_pin_in,
  input  wire logic [7:0] lo_in,
  input  wire logic [7:0] hi_in,
  input  wire logic       hi_oe_in,
  input  wire logic       ale_in,
  input  wire logic       rd_n_in,
  input  wire logic       wr_n_in,
  output logic      [7:0] data_out
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat_q;
  logic [15:0] a;
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
  // transparent while strobe high, frozen from its fall
  always_latch if (ale_in) lat_q <= ad_pin_in;
  assign a = {hi_oe_in ? hi_in : port_hi_in, mux_in ? lat_q : lo_in};
  // store taken once the strobe cycle has settled, clear of edge races
  always @(negedge wr_n_in) #2 if (!wr_n_in) mem[a] = ad_pin_in;
  // released bus shows the inverse, so a late sample cannot pass
  assign data_out = !rd_n_in ? mem[a] : ~mem[a];
endmodule
`default_nettype wire

// >>> emim_asserts.sv
// checker for emim_top, bound at the foot of this file
// assumes one clock domain with asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module emim_asserts (
  input wire logic        clk_sys_in,
  input wire logic        resetn_in,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [15:0] paddr,
  input wire logic        pslverr,
  input wire logic        xreq_in,
  input wire logic        xwide_in,
  input wire logic [15:0] xaddr_in,
  input wire logic [7:0]  xwdata_in,
  input wire logic        xdone_out,
  input wire logic [7:0]  ad_out,
  input wire logic [7:0]  ad_oe_out,
  input wire logic [7:0]  addr_hi_out,
  input wire logic        addr_hi_oe_out,
  input wire logic        ale_out,
  input wire logic        rd_n_out,
  input wire logic        wr_n_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  logic strb;
  assign strb = !rd_n_out || !wr_n_out;
  a_strobe_excl: assert property (!(!rd_n_out && !wr_n_out))
    else $error("load and store strobes both low");
  a_ale_lowaddr: assert property (ale_out |-> ad_oe_out == 8'hFF && ad_out == xaddr_in[7:0])
    else $error("latch phase without low address");
  a_ale_gap: assert property ($fell(ale_out) |-> !strb)
    else $error("strobe at latch fall");
  a_store_data: assert property (!wr_n_out |-> ad_oe_out == 8'hFF && ad_out == xwdata_in)
    else $error("store data missing");
  a_load_float: assert property (!rd_n_out |-> ad_oe_out == 8'h00)
    else $error("bus driven during load");
  a_wide_hiaddr: assert property (strb && xwide_in |-> addr_hi_oe_out && addr_hi_out == xaddr_in[15:8])
    else $error("wide access upper address wrong");
  a_done_bound: assert property ($rose(xreq_in) |-> ##[4:12] xdone_out)
    else $error("access not finished in time");
  a_done_pulse: assert property (xdone_out |=> !xdone_out)
    else $error("done longer than one cycle");
  a_strobe_inreq: assert property (strb || ale_out |-> xreq_in)
    else $error("strobe outside an access");
  a_cfg_mapped: assert property (psel && penable && paddr == 16'h02AC |-> !pslverr)
    else $error("config access refused");
endmodule
bind emim_top emim_asserts u_chk (.clk_sys_in, .resetn_in, .psel, .penable, .paddr, .pslverr,
  .xreq_in, .xwide_in, .xaddr_in, .xwdata_in, .xdone_out, .ad_out, .ad_oe_out, .addr_hi_out,
  .addr_hi_oe_out, .ale_out, .rd_n_out, .wr_n_out);
`default_nettype wire

// >>> external_memory_interface_mode_bench.sv
// self-checking bench for emim_top with a static memory model on its pins
// assumes byte address is register index times four
`timescale 1ns/1ps
`default_nettype none
module external_memory_interface_mode_bench;
  logic clk_sys_in = 0, resetn_in = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic xreq_in = 0, xwrite_in = 0, xwide_in = 0, xdone_out, ale_out, rd_n_out, wr_n_out;
  logic hoe, mux, wd, off, rerr;
  logic [15:0] paddr = 0, xaddr_in = 0, a, ea, ex;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [7:0] xwdata_in = 0, port_hi = 0, xrdata_out, ad_out, ad_oe_out, ad_in, md, lo, hi;
  logic [7:0] d, ph, pg, rd;
  logic [1:0] m;
  int failures = 0, cmp_count = 0, ale;
  emim_top dut (.clk_sys_in, .resetn_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .xreq_in, .xwrite_in, .xwide_in, .xaddr_in, .xwdata_in,
    .port_hi_latch_in(port_hi), .xdone_out, .xrdata_out, .ad_out, .ad_oe_out, .ad_in,
    .addr_lo_out(lo), .addr_hi_out(hi), .addr_hi_oe_out(hoe), .ale_out, .rd_n_out, .wr_n_out);
  emim_sram sram (.mux_in(mux), .port_hi_in(port_hi), .ad_pin_in(ad_in), .lo_in(lo),
    .hi_in(hi), .hi_oe_in(hoe), .ale_in(ale_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
    .data_out(md));
  // bus wire: whoever enables wins, the model otherwise
  assign ad_in = (ad_oe_out & ad_out) | (~ad_oe_out & md);
  initial forever #5 clk_sys_in = ~clk_sys_in;
  function automatic int lat(logic o, logic mx, int al);
    return o && mx ? 2 * al + 6 : 4;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] ad, input logic [31:0] wv);
    @(posedge clk_sys_in);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wv;
    @(posedge clk_sys_in);
    penable <= 1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // done is seen mid-cycle; the request drops at the edge after it
  task automatic xfer(input logic w, input logic [15:0] xa);
    int n = 0, na = 0, ns = 0;
    logic so = 0;
    @(posedge clk_sys_in);
    xreq_in <= 1;
    xwrite_in <= w;
    xwide_in <= wd;
    xaddr_in <= xa;
    xwdata_in <= d;
    port_hi <= ph;
    do begin
      @(negedge clk_sys_in);
      n++;
      na += ale_out;
      if (!rd_n_out || !wr_n_out) begin
        ns++;
        so = hoe;
      end
    end while (xdone_out !== 1'b1 && n < 40);
    rd = xrdata_out;
    @(posedge clk_sys_in);
    xreq_in <= 0;
    chk("latency", n, lat(off, mux, ale) + 1);
    chk("latch cycles", na, off && mux ? ale + 1 : 0);
    chk("strobe cycles", ns, off);
    if (off) chk("upper drive", so, wd || m == 2'b10);
  endtask
  initial begin
    void'($urandom(32'hBDC7));
    repeat (10) @(posedge clk_sys_in);
    resetn_in <= 1;
    apb(0, 16'h02AC, 0);
    chk("cfg reset", rdat, 32'h03);
    apb(0, 16'h02B0, 0);
    chk("status idle", rdat, 32'h01);
    apb(1, 16'h02AC, 32'hFFFFFFFF);
    apb(0, 16'h02AC, 0);
    chk("cfg top bits", rdat, 32'h1F);
    apb(0, 16'h0300, 0);
    chk("unmapped", {rerr, rdat[30:0]}, 32'h80000000);
    // every mux, mode and latch width setting
    for (int c = 0; c < 32; c++) begin
      mux = !c[4];
      m = 2'(c >> 2);
      ale = c % 4;
      pg = $urandom % 2 ? 8'($urandom % 32) : 8'($urandom);
      apb(1, 16'h02A8, {24'h0, pg});
      apb(1, 16'h02AC, 32'(c));
      repeat (4) begin
        a = 16'($urandom);
        if ($urandom % 2) a[15:13] = 3'h0;
        wd = 1'($urandom);
        d = 8'($urandom);
        ph = 8'($urandom);
        ea = wd ? a : {pg, a[7:0]};
        off = m == 2'b11 || (m != 2'b00 && ea >= 16'h2000);
        ex = wd || m == 2'b10 ? ea : {ph, a[7:0]};
        xfer(1, a);
        if (off) chk("ext cell", sram.mem[ex], d);
        xfer(0, m == 2'b00 ? a ^ {3'($urandom), 13'h0} : a);
        chk("load", rd, d);
      end
    end
    final_report();
  end
  initial begin
    repeat (50000) @(posedge clk_sys_in);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
